// *** logic/pmcu_pkg.sv ***
package pmcu_pkg;
    // --------------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------------
    localparam logic [11:0] PMCU_POWER_MANAGEMENT_CONTROL = 12'h014;
    localparam logic [31:0] PMCU_READ_UNMAPPED = 32'h0000_0000;

    // --------------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------------
    localparam int PMCU_BIT_ANALOG_REF_WAIT_DISABLE    = 15;
    localparam int PMCU_BIT_CRYSTAL_SUSPEND_DISABLE    = 14;
    localparam int PMCU_BIT_EEE_WAKE_ENABLE            = 13;
    localparam int PMCU_BIT_EEE_WAKE_STATUS            = 12;
    localparam int PMCU_BIT_MAC_DOMAIN_SOFT_RESET      = 11;
    localparam int PMCU_BIT_RESUME_CLEARS_WAKE_STATUS  = 9;
    localparam int PMCU_BIT_RESUME_CLEARS_WAKE_ENABLES = 8;

    // --------------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------------
    localparam logic PMCU_RST_ANALOG_REF_WAIT_DISABLE    = 1'h0;
    localparam logic PMCU_RST_CRYSTAL_SUSPEND_DISABLE    = 1'h0;
    localparam logic PMCU_RST_EEE_WAKE_ENABLE            = 1'h0;
    localparam logic PMCU_RST_EEE_WAKE_STATUS            = 1'h0;
    localparam logic PMCU_RST_MAC_DOMAIN_SOFT_RESET      = 1'h0;
    localparam logic PMCU_RST_RESUME_CLEARS_WAKE_STATUS  = 1'h0;
    localparam logic PMCU_RST_RESUME_CLEARS_WAKE_ENABLES = 1'h1;

    // --------------------------------------------------------------------
    // Suspend-state selection
    // --------------------------------------------------------------------
    localparam logic [1:0] PMCU_DEEP_SUSPEND_STATE = 2'h2;

    // --------------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------------
    localparam int PMCU_CLK_HZ             = 20_000_000;
    localparam int PMCU_PHY_RESET_REQUEST_MIN_MS     = 4;
    localparam int PMCU_PHY_RESET_REQUEST_LONG_MS    = 128;
    localparam int PMCU_ANA_REF_SETTLE_MS  = 100;
    localparam int PMCU_PHY_RESET_REQUEST_MIN_CYC    = PMCU_CLK_HZ / 1000 * PMCU_PHY_RESET_REQUEST_MIN_MS;
    localparam int PMCU_PHY_RESET_REQUEST_LONG_CYC   = PMCU_CLK_HZ / 1000 * PMCU_PHY_RESET_REQUEST_LONG_MS;
    localparam int PMCU_ANA_REF_SETTLE_CYC = PMCU_CLK_HZ / 1000 * PMCU_ANA_REF_SETTLE_MS;
    localparam int PMCU_CNT_W              = 22;

    typedef enum logic [1:0] {
        PMCU_PHY_IDLE   = 2'b00,
        PMCU_PHY_RESET  = 2'b01,
        PMCU_PHY_SETTLE = 2'b10
    } pmcu_phy_state_t;
endpackage

// *** logic/pmcu_sync2.sv ***
`timescale 1ns/1ps
module pmcu_sync2 (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      sync_out
);
    logic stage1;
    logic next_stage1;
    logic next_sync_out;

    always_comb begin
        next_stage1   = async_in;
        next_sync_out = stage1;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stage1   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule // pmcu_sync2

// *** logic/pmcu_phy_seq.sv ***
`timescale 1ns/1ps
module pmcu_phy_seq #(
    parameter int RST_MIN_CYC = pmcu_pkg::PMCU_PHY_RESET_REQUEST_MIN_CYC,
    parameter int RST_LONG_CYC = pmcu_pkg::PMCU_PHY_RESET_REQUEST_LONG_CYC,
    parameter int SETTLE_CYC   = pmcu_pkg::PMCU_ANA_REF_SETTLE_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic start,
    input  wire logic keep_ref,
    output logic      phy_reset,
    output logic      analog_ref_enable,
    output logic      busy
);
    import pmcu_pkg::*;

    pmcu_phy_state_t         state;
    pmcu_phy_state_t         next_state;
    logic [PMCU_CNT_W-1:0]   count;
    logic [PMCU_CNT_W-1:0]   next_count;
    logic                    ref_off;
    logic                    next_ref_off;

    always_comb begin
        next_state   = state;
        next_count   = count;
        next_ref_off = ref_off;
        case (state)
            PMCU_PHY_IDLE: begin
                if (start) begin
                    next_state   = PMCU_PHY_RESET;
                    next_count   = '0;
                    // With the wait disabled the reference stays up, saving the long settle.
                    next_ref_off = !keep_ref;
                end
            end
            PMCU_PHY_RESET: begin
                next_count = count + 1'b1;
                if (32'(count) >= RST_MIN_CYC - 1) begin
                    next_count = '0;
                    next_state = ref_off ? PMCU_PHY_SETTLE : PMCU_PHY_IDLE;
                end
            end
            PMCU_PHY_SETTLE: begin
                next_ref_off = 1'b0;
                next_count   = count + 1'b1;
                if (32'(count) >= SETTLE_CYC - 1) begin
                    next_state = PMCU_PHY_IDLE;
                end
            end
            default: next_state = PMCU_PHY_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state   <= PMCU_PHY_IDLE;
            count   <= '0;
            ref_off <= 1'b0;
        end else begin
            state   <= next_state;
            count   <= next_count;
            ref_off <= next_ref_off;
        end
    end

    // PHY held in reset through the settle phase too, total stays under the long limit.
    assign phy_reset         = (state != PMCU_PHY_IDLE);
    assign analog_ref_enable = !ref_off;
    assign busy              = phy_reset;

    a_ref_kept_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state == PMCU_PHY_IDLE && start && keep_ref) |=> analog_ref_enable)
        else $error("reference dropped while wait disabled");
    a_settle_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(state == PMCU_PHY_SETTLE) |-> phy_reset [*8])
        else $error("settle ended too early");
endmodule // pmcu_phy_seq

// *** logic/pmcu_top.sv ***
`timescale 1ns/1ps
module pmcu_top #(
    parameter int PHY_RESET_REQUEST_MIN_CYC = pmcu_pkg::PMCU_PHY_RESET_REQUEST_MIN_CYC,
    parameter int ANA_SETTLE_CYC  = pmcu_pkg::PMCU_ANA_REF_SETTLE_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        protect_rst_n,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        phy_reset_request,
    input  wire logic [1:0]  suspend_select,
    input  wire logic        in_state_a,
    input  wire logic        eee_wake_event,
    input  wire logic        resume_done,
    input  wire logic        resume_remote,
    input  wire logic        mac_rx_clk_running,
    input  wire logic        mac_tx_clk_running,
    output logic             phy_reset,
    output logic             analog_ref_enable,
    output logic             phy_busy,
    output logic             crystal_enable,
    output logic             eee_wake_request,
    output logic             mac_rx_reset,
    output logic             mac_tx_reset,
    output logic             wake_status_clear,
    output logic             wake_enables_clear
);
    import pmcu_pkg::*;

    // ------------------------------------------------------------------
    // Register fields
    // ------------------------------------------------------------------
    logic analog_ref_wait_disable;
    logic crystal_suspend_disable;
    logic eee_wake_enable;
    logic eee_wake_status;
    logic mac_domain_soft_reset;
    logic resume_clears_wake_status;
    logic resume_clears_wake_enables;
    logic next_analog_ref_wait_disable;
    logic next_crystal_suspend_disable;
    logic next_eee_wake_enable;
    logic next_eee_wake_status;
    logic next_mac_domain_soft_reset;
    logic next_resume_clears_wake_status;
    logic next_resume_clears_wake_enables;
    logic [31:0] next_reg_rdata;
    logic        hit;
    logic        wr_hit;
    logic        remote_resume;
    logic        rx_clk_ok;
    logic        tx_clk_ok;
    logic        eee_evt;

    assign hit           = (reg_addr == PMCU_POWER_MANAGEMENT_CONTROL);
    assign wr_hit        = reg_wr && hit;
    // Host resumes never touch status or enables.
    assign remote_resume = resume_done && resume_remote;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    pmcu_sync2 u_sync_rx (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in (mac_rx_clk_running),
        .sync_out (rx_clk_ok)
    );
    pmcu_sync2 u_sync_tx (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in (mac_tx_clk_running),
        .sync_out (tx_clk_ok)
    );
    pmcu_sync2 u_sync_eee (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in (eee_wake_event),
        .sync_out (eee_evt)
    );

    // ------------------------------------------------------------------
    // Protected-domain bits
    // ------------------------------------------------------------------
    always_comb begin
        next_analog_ref_wait_disable = analog_ref_wait_disable;
        next_crystal_suspend_disable = crystal_suspend_disable;
        if (wr_hit) begin
            next_analog_ref_wait_disable = reg_wdata[PMCU_BIT_ANALOG_REF_WAIT_DISABLE];
            next_crystal_suspend_disable = reg_wdata[PMCU_BIT_CRYSTAL_SUSPEND_DISABLE];
        end
    end

    // Only the protect reset reaches these, so ordinary resets leave them alone.
    always_ff @(posedge sys_clk) begin
        if (!protect_rst_n) begin
            analog_ref_wait_disable <= PMCU_RST_ANALOG_REF_WAIT_DISABLE;
            crystal_suspend_disable <= PMCU_RST_CRYSTAL_SUSPEND_DISABLE;
        end else begin
            analog_ref_wait_disable <= next_analog_ref_wait_disable;
            crystal_suspend_disable <= next_crystal_suspend_disable;
        end
    end

    // ------------------------------------------------------------------
    // Ordinary-domain bits
    // ------------------------------------------------------------------
    always_comb begin
        next_eee_wake_enable            = eee_wake_enable;
        next_eee_wake_status            = eee_wake_status;
        next_mac_domain_soft_reset      = mac_domain_soft_reset;
        next_resume_clears_wake_status  = resume_clears_wake_status;
        next_resume_clears_wake_enables = resume_clears_wake_enables;
        if (wr_hit) begin
            next_eee_wake_enable            = reg_wdata[PMCU_BIT_EEE_WAKE_ENABLE];
            next_mac_domain_soft_reset      = reg_wdata[PMCU_BIT_MAC_DOMAIN_SOFT_RESET];
            next_resume_clears_wake_status  = reg_wdata[PMCU_BIT_RESUME_CLEARS_WAKE_STATUS];
            next_resume_clears_wake_enables = reg_wdata[PMCU_BIT_RESUME_CLEARS_WAKE_ENABLES];
            if (reg_wdata[PMCU_BIT_EEE_WAKE_STATUS]) begin
                next_eee_wake_status = 1'b0;
            end
        end
        if (remote_resume && resume_clears_wake_enables) begin
            next_eee_wake_enable = 1'b0;
        end
        if (remote_resume && resume_clears_wake_status) begin
            next_eee_wake_status = 1'b0;
        end
        // A new event beats any clear in the same cycle, enable or not.
        if (eee_evt) begin
            next_eee_wake_status = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            eee_wake_enable            <= PMCU_RST_EEE_WAKE_ENABLE;
            eee_wake_status            <= PMCU_RST_EEE_WAKE_STATUS;
            mac_domain_soft_reset      <= PMCU_RST_MAC_DOMAIN_SOFT_RESET;
            resume_clears_wake_status  <= PMCU_RST_RESUME_CLEARS_WAKE_STATUS;
            resume_clears_wake_enables <= PMCU_RST_RESUME_CLEARS_WAKE_ENABLES;
        end else begin
            eee_wake_enable            <= next_eee_wake_enable;
            eee_wake_status            <= next_eee_wake_status;
            mac_domain_soft_reset      <= next_mac_domain_soft_reset;
            resume_clears_wake_status  <= next_resume_clears_wake_status;
            resume_clears_wake_enables <= next_resume_clears_wake_enables;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        next_reg_rdata = PMCU_READ_UNMAPPED;
        if (reg_rd && hit) begin
            next_reg_rdata[PMCU_BIT_ANALOG_REF_WAIT_DISABLE]    = analog_ref_wait_disable;
            next_reg_rdata[PMCU_BIT_CRYSTAL_SUSPEND_DISABLE]    = crystal_suspend_disable;
            next_reg_rdata[PMCU_BIT_EEE_WAKE_ENABLE]            = eee_wake_enable;
            next_reg_rdata[PMCU_BIT_EEE_WAKE_STATUS]            = eee_wake_status;
            next_reg_rdata[PMCU_BIT_MAC_DOMAIN_SOFT_RESET]      = mac_domain_soft_reset;
            next_reg_rdata[PMCU_BIT_RESUME_CLEARS_WAKE_STATUS]  = resume_clears_wake_status;
            next_reg_rdata[PMCU_BIT_RESUME_CLEARS_WAKE_ENABLES] = resume_clears_wake_enables;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------------
    // PHY reset sequencing
    // ------------------------------------------------------------------
    pmcu_phy_seq #(
        .RST_MIN_CYC  (PHY_RESET_REQUEST_MIN_CYC),
        .RST_LONG_CYC (PMCU_PHY_RESET_REQUEST_LONG_CYC),
        .SETTLE_CYC   (ANA_SETTLE_CYC)
    ) u_phy_seq (
        .sys_clk           (sys_clk),
        .rst_n             (rst_n),
        .start             (phy_reset_request),
        .keep_ref          (analog_ref_wait_disable),
        .phy_reset         (phy_reset),
        .analog_ref_enable (analog_ref_enable),
        .busy              (phy_busy)
    );

    // ------------------------------------------------------------------
    // Outputs to the surrounding power logic
    // ------------------------------------------------------------------
    // State_a and deep suspend are the states where the crystal would stop.
    assign crystal_enable = crystal_suspend_disable
                         || !(in_state_a || suspend_select == PMCU_DEEP_SUSPEND_STATE);
    assign eee_wake_request   = eee_wake_enable && eee_wake_status;
    // Release waits for a running clock; assertion on a stopped clock also waits out the two-stage synchroniser.
    assign mac_rx_reset       = mac_domain_soft_reset || !rx_clk_ok;
    assign mac_tx_reset       = mac_domain_soft_reset || !tx_clk_ok;
    assign wake_status_clear  = remote_resume && resume_clears_wake_status;
    assign wake_enables_clear = remote_resume && resume_clears_wake_enables;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_status_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        eee_evt |=> eee_wake_status)
        else $error("eee status not set by event");
    a_status_w1c: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_hit && reg_wdata[PMCU_BIT_EEE_WAKE_STATUS] && !eee_evt) |=> !eee_wake_status)
        else $error("eee status not cleared by write");
    a_resume_clr_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (remote_resume && resume_clears_wake_status && !eee_evt) |=> !eee_wake_status)
        else $error("remote resume left status");
    a_host_keeps_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (resume_done && !resume_remote && !wr_hit) |=> $stable(eee_wake_status) || eee_wake_status)
        else $error("host resume changed status");
    a_policy_off_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (resume_done && !resume_clears_wake_status && !eee_evt
            && !(wr_hit && reg_wdata[PMCU_BIT_EEE_WAKE_STATUS]))
        |-> (!wake_status_clear ##1 $stable(eee_wake_status)))
        else $error("status clear with policy off");
    a_resume_clr_en: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (remote_resume && resume_clears_wake_enables) |=> !eee_wake_enable)
        else $error("remote resume left enable");
    a_host_keeps_en: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (resume_done && !resume_remote && !wr_hit) |=> $stable(eee_wake_enable))
        else $error("host resume changed enable");
    a_mac_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mac_domain_soft_reset |-> (mac_rx_reset && mac_tx_reset))
        else $error("mac domains not held");
    a_mac_clk_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!rx_clk_ok || !tx_clk_ok)
        |-> ((rx_clk_ok || mac_rx_reset) && (tx_clk_ok || mac_tx_reset)))
        else $error("mac released without clock");
    a_phy_min_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(phy_reset) |-> phy_reset [*8])
        else $error("phy reset too short");
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd |=> (reg_rdata[31:16] == 16'h0000 && reg_rdata[10] == 1'b0))
        else $error("reserved bits not zero");

    // ------------------------------------------------------------------
    // Field, read-path and output checks
    // ------------------------------------------------------------------
    a_status_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!eee_evt && !(wr_hit && reg_wdata[PMCU_BIT_EEE_WAKE_STATUS])
            && !(remote_resume && resume_clears_wake_status))
        |=> $stable(eee_wake_status))
        else $error("eee status changed without cause");
    a_enable_written: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wr_hit && !(remote_resume && resume_clears_wake_enables))
        |=> (eee_wake_enable == $past(reg_wdata[PMCU_BIT_EEE_WAKE_ENABLE])))
        else $error("eee enable not written");
    a_policy_written: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_hit |=> ((resume_clears_wake_status
                     == $past(reg_wdata[PMCU_BIT_RESUME_CLEARS_WAKE_STATUS]))
                 && (resume_clears_wake_enables
                     == $past(reg_wdata[PMCU_BIT_RESUME_CLEARS_WAKE_ENABLES]))))
        else $error("resume policy not written");
    a_crystal_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (in_state_a || suspend_select == PMCU_DEEP_SUSPEND_STATE)
        |-> (crystal_enable == crystal_suspend_disable))
        else $error("crystal state wrong in deep suspend");
    a_protect_kept: assert property (@(posedge sys_clk) disable iff (!protect_rst_n)
        (!rst_n && !wr_hit) |=> ($stable(analog_ref_wait_disable)
            && $stable(crystal_suspend_disable)))
        else $error("protected bits lost in reset");
    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(reg_rd && hit)
        |=> (reg_rdata == 32'h0000_0000))
        else $error("read data outside read cycle");
    a_mac_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!mac_domain_soft_reset && rx_clk_ok && tx_clk_ok)
        |-> (!mac_rx_reset && !mac_tx_reset))
        else $error("mac held without cause");
endmodule // pmcu_top

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import pmcu_pkg::*;
    localparam logic [11:0] REG_A = PMCU_POWER_MANAGEMENT_CONTROL;
    logic        sys_clk, rst_n, protect_rst_n, reg_wr, reg_rd, phy_reset_request;
    logic        in_state_a, eee_wake_event, resume_done, resume_remote;
    logic        mac_rx_clk_running, mac_tx_clk_running, phy_reset, analog_ref_enable;
    logic        phy_busy, crystal_enable, eee_wake_request, mac_rx_reset, mac_tx_reset;
    logic        wake_status_clear, wake_enables_clear;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [1:0]  suspend_select;
    int          mismatches, samples_checked;

    pmcu_top #(.PHY_RESET_REQUEST_MIN_CYC(16), .ANA_SETTLE_CYC(20)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .protect_rst_n(protect_rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .phy_reset_request(phy_reset_request),
        .suspend_select(suspend_select), .in_state_a(in_state_a),
        .eee_wake_event(eee_wake_event), .resume_done(resume_done),
        .resume_remote(resume_remote), .mac_rx_clk_running(mac_rx_clk_running),
        .mac_tx_clk_running(mac_tx_clk_running), .phy_reset(phy_reset),
        .analog_ref_enable(analog_ref_enable), .phy_busy(phy_busy),
        .crystal_enable(crystal_enable), .eee_wake_request(eee_wake_request),
        .mac_rx_reset(mac_rx_reset), .mac_tx_reset(mac_tx_reset),
        .wake_status_clear(wake_status_clear), .wake_enables_clear(wake_enables_clear)
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic summarize;
        if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic check_reg(input logic [31:0] exp);
        logic [31:0] d;
        rd(REG_A, d);
        check(d, exp);
    endtask

    // The event passes a two-stage synchroniser, so it is held for three cycles.
    task automatic eee_pulse;
        @(posedge sys_clk);
        eee_wake_event <= 1'b1;
        repeat (3) @(posedge sys_clk);
        eee_wake_event <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic resume(input logic remote, input logic exp_st, input logic exp_en);
        @(posedge sys_clk);
        resume_done <= 1'b1; resume_remote <= remote;
        #1 check({30'h0, wake_status_clear, wake_enables_clear}, {30'h0, exp_st, exp_en});
        @(posedge sys_clk);
        resume_done <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] d;
        check_reg(32'h0000_0100);
        wr(REG_A, 32'hFFFF_FFFF);
        check_reg(32'h0000_EB00);
        @(posedge sys_clk);
        #1 check(reg_rdata, 32'h0000_0000);
        check({mac_rx_reset, mac_tx_reset}, 32'h3);
        wr(12'h018, 32'hFFFF_FFFF);
        rd(12'h018, d);
        check(d, 32'h0000_0000);
        check_reg(32'h0000_EB00);
        wr(REG_A, 32'h0000_0000);
        repeat (4) @(posedge sys_clk);
        #1 check({mac_rx_reset, mac_tx_reset}, 32'h0);
        mac_rx_clk_running <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 check({mac_rx_reset, mac_tx_reset}, 32'h2);
        mac_rx_clk_running <= 1'b1;
    endtask

    task automatic t_eee;
        eee_pulse();
        check_reg(32'h0000_1000);
        check(eee_wake_request, 1'b0);
        wr(REG_A, 32'h0000_2000);
        #1 check(eee_wake_request, 1'b1);
        wr(REG_A, 32'h0000_3000);
        check_reg(32'h0000_2000);
    endtask

    task automatic t_resume;
        wr(REG_A, 32'h0000_2300);
        eee_pulse();
        resume(1'b0, 1'b0, 1'b0);
        check_reg(32'h0000_3300);
        resume(1'b1, 1'b1, 1'b1);
        check_reg(32'h0000_0300);
        wr(REG_A, 32'h0000_2000);
        eee_pulse();
        resume(1'b1, 1'b0, 1'b0);
        check_reg(32'h0000_3000);
    endtask

    task automatic t_crystal;
        logic [3:0] cfg [4] = '{4'h0, 4'h2, 4'h5, 4'hE};
        logic       exp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            wr(REG_A, {16'h0, 1'b0, cfg[i][3], 14'h0});
            in_state_a <= cfg[i][2];
            suspend_select <= cfg[i][1:0];
            @(posedge sys_clk);
            #1 check(crystal_enable, exp[i]);
        end
    endtask

    task automatic t_phy(input logic keep);
        int n;
        wr(REG_A, {16'h0, keep, 15'h0});
        @(posedge sys_clk);
        phy_reset_request <= 1'b1;
        @(posedge sys_clk);
        phy_reset_request <= 1'b0;
        #1 check({phy_busy, analog_ref_enable}, {30'h0, 1'b1, keep});
        n = 0;
        // A second request in mid-reset must not restart the count.
        while (phy_reset === 1'b1 && n < 200) begin
            n++;
            phy_reset_request <= (n == 5);
            @(posedge sys_clk);
            #1;
        end
        if (n == 200) begin
            mismatches++;
            summarize();
        end
        check(n, keep ? 32'd16 : 32'd36);
        check(analog_ref_enable, 1'b1);
    endtask

    task automatic t_protect;
        wr(REG_A, 32'h0000_C000);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        check_reg(32'h0000_C100);
        protect_rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        protect_rst_n <= 1'b1;
        check_reg(32'h0000_0100);
    endtask

    initial begin
        rst_n = 1'b0; protect_rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 12'h000; reg_wdata = 32'h0; phy_reset_request = 1'b0;
        suspend_select = PMCU_DEEP_SUSPEND_STATE; in_state_a = 1'b0;
        eee_wake_event = 1'b0; resume_done = 1'b0; resume_remote = 1'b0;
        mac_rx_clk_running = 1'b1; mac_tx_clk_running = 1'b1;
        mismatches = 0; samples_checked = 0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1; protect_rst_n <= 1'b1;
        t_regs();
        t_eee();
        t_resume();
        t_crystal();
        t_phy(1'b1);
        t_phy(1'b0);
        t_protect();
        summarize();
    end
endmodule // testbench
